// *** logic/tcpu_pkg.sv ***
// Functional notes
// - Two 16-bit compare values checked every tick.
// - Compare values software-owned, reset to 8000h.
// - Match sets the channel match flag.
// - Enabled pin takes level; latch low in reset.
// - Match interrupt needs enable and clear mask.
// - Flag clears: status read, then low access.
// - High write inhibits matching until low write.
// - Pin enable clear: no level, interrupt still.
// - Divide-by-two matches at value, else plus one.
// - Tick is clock over 2, 4, 8 or external.
// - Force copies level to pin, no flag.
// - Force ignored in single-pulse or PWM mode.
// - Single pulse: capture one triggers, compare ends.
// - Trigger edge loads FFFCh, starts pulse, captures FFFDh.
// - Compare one match ends the pulse.
// - Single pulse: no flag one; channel two flags.
// - Equal levels give constant pin level.
// - Single pulse: capture one blocked, two works.
// - Both mode bits set means PWM only.
// - PWM uses channel one plus compare two.
// - PWM compare values reload at period end.
// - PWM compare two match reloads counter FFFCh.
// - PWM sets no match flags; capture flag one.
package tcpu_pkg;

  // Register offsets on the byte bus.
  localparam logic [3:0] TCPU_ADDR_CTRL_ONE  = 4'h0;
  localparam logic [3:0] TCPU_ADDR_CTRL_TWO  = 4'h1;
  localparam logic [3:0] TCPU_ADDR_STATUS    = 4'h2;
  localparam logic [3:0] TCPU_ADDR_CMP1_HIGH = 4'h3;
  localparam logic [3:0] TCPU_ADDR_CMP1_LOW  = 4'h4;
  localparam logic [3:0] TCPU_ADDR_CMP2_HIGH = 4'h5;
  localparam logic [3:0] TCPU_ADDR_CMP2_LOW  = 4'h6;

  // Control one field positions.
  localparam int TCPU_C1_LEVEL_ONE   = 0;
  localparam int TCPU_C1_LEVEL_TWO   = 1;
  localparam int TCPU_C1_FORCE_ONE   = 2;
  localparam int TCPU_C1_FORCE_TWO   = 3;
  localparam int TCPU_C1_CAP_EDGE    = 4;
  localparam int TCPU_C1_CMP_IRQ_EN  = 6;
  localparam int TCPU_C1_CAP_IRQ_EN  = 7;

  // Control two field positions.
  localparam int TCPU_C2_PIN_EN_ONE  = 0;
  localparam int TCPU_C2_PIN_EN_TWO  = 1;
  localparam int TCPU_C2_SINGLE      = 2;
  localparam int TCPU_C2_PWM         = 3;
  localparam int TCPU_C2_CLK_SEL_LO  = 4;
  localparam int TCPU_C2_EXT_EDGE    = 6;

  // Status field positions.
  localparam int TCPU_SR_MATCH_ONE   = 0;
  localparam int TCPU_SR_MATCH_TWO   = 1;

  // Reset and load values.
  localparam logic [15:0] TCPU_CMP_RESET     = 16'h8000;
  localparam logic [15:0] TCPU_COUNTER_LOAD  = 16'hfffc;
  localparam logic [15:0] TCPU_CAPTURE_VALUE = 16'hfffd;
  localparam logic [7:0]  TCPU_CTRL_RESET    = 8'h00;
  localparam logic [2:0]  TCPU_PRESCALE_FACTOR_RESET   = 3'h0;

  // Clock select codes and prescaler terminal masks.
  localparam logic [1:0] TCPU_CLK_DIV2 = 2'h0;
  localparam logic [1:0] TCPU_CLK_DIV4 = 2'h1;
  localparam logic [1:0] TCPU_CLK_DIV8 = 2'h2;
  localparam logic [1:0] TCPU_CLK_EXT  = 2'h3;
  localparam logic [2:0] TCPU_MASK_DIV2 = 3'h1;
  localparam logic [2:0] TCPU_MASK_DIV4 = 3'h3;
  localparam logic [2:0] TCPU_MASK_DIV8 = 3'h7;

endpackage

// *** logic/tcpu_compare_unit.sv ***
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module tcpu_compare_unit
  import tcpu_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Counter and processor side.
  input  wire logic [15:0] counter_value,
  input  wire logic        cpu_irq_mask,
  output logic             timer_tick,
  output logic             counter_load_req,
  // Capture path side.
  input  wire logic        capture_pin_one,
  input  wire logic        ext_clock_pin,
  output logic             capture_one_block,
  output logic             capture_one_load,
  output logic      [15:0] capture_one_value,
  // Pins and interrupt.
  output logic             compare_output_pin_one,
  output logic             compare_output_pin_two,
  output logic             compare_pin_enable_one,
  output logic             compare_pin_enable_two,
  output logic             timer_irq_req
);

  // Whole state of the unit in one record.
  typedef struct packed {
    logic [1:0]  rst_sync;      // Reset release pipeline.
    logic [7:0]  ctrl_one;      // Levels, edge and enables.
    logic [7:0]  ctrl_two;      // Pin enables, modes, clock.
    logic [1:0]  match_flag;    // Sticky match flags.
    logic [1:0]  clear_armed;   // Status read seen with flag set.
    logic [1:0]  inhibit;       // High byte written, low pending.
    logic [15:0] cmp_one;       // Software compare value one.
    logic [15:0] cmp_two;       // Software compare value two.
    logic [15:0] act_one;       // Value compared on channel one.
    logic [15:0] act_two;       // Value compared on channel two.
    logic [15:0] cnt_prev;      // Counter seen last cycle.
    logic [2:0]  prescale_factor;         // Prescaler phase.
    logic        ext_prev;      // External clock last sample.
    logic        cap_prev;      // Capture pin one last sample.
    logic [7:0]  rdata;         // Read data output.
    logic        tick;          // Timer tick output.
    logic        load_req;      // Counter reload request.
    logic        cap_load;      // Capture one load pulse.
    logic        cap_block;     // Ordinary capture one off.
    logic [1:0]  pin;           // Compare output latches.
    logic        irq;           // Interrupt request.
  } tcpu_state_s;

  tcpu_state_s st_q;  // Registered state.
  tcpu_state_s st_d;  // Next state.

  // Decodes whether an access targets the low byte of a channel.
  function automatic logic tcpu_is_low(input logic [3:0] addr, input logic ch);
    tcpu_is_low = (addr == (ch ? TCPU_ADDR_CMP2_LOW : TCPU_ADDR_CMP1_LOW));
  endfunction

  // Decodes whether an access targets the high byte of a channel.
  function automatic logic tcpu_is_high(input logic [3:0] addr, input logic ch);
    tcpu_is_high = (addr == (ch ? TCPU_ADDR_CMP2_HIGH : TCPU_ADDR_CMP1_HIGH));
  endfunction

  // Mode and field views of the control registers.
  logic        mode_pwm;     // PWM mode active.
  logic        mode_single;  // Single-pulse mode active.
  logic [1:0]  clk_sel;      // Timer clock selection.
  logic [2:0]  prescale_factor_mask;   // Prescaler terminal mask.
  logic        ext_edge;     // Active external clock edge.
  logic        cap_edge;     // Active capture one edge.
  logic        cnt_moved;    // Counter changed this cycle.
  logic [1:0]  match;        // Match event per channel.
  logic [1:0]  pin_en;       // Pin enables.
  logic [1:0]  level;        // Programmed output levels.

  // Field extraction and event detection.
  always_comb begin
    mode_pwm    = st_q.ctrl_two[TCPU_C2_PWM];
    mode_single = st_q.ctrl_two[TCPU_C2_SINGLE] & ~st_q.ctrl_two[TCPU_C2_PWM];
    clk_sel     = st_q.ctrl_two[TCPU_C2_CLK_SEL_LO +: 2];
    pin_en      = {st_q.ctrl_two[TCPU_C2_PIN_EN_TWO], st_q.ctrl_two[TCPU_C2_PIN_EN_ONE]};
    level       = {st_q.ctrl_one[TCPU_C1_LEVEL_TWO], st_q.ctrl_one[TCPU_C1_LEVEL_ONE]};
    // Terminal mask picks the prescale factor.
    unique case (clk_sel)
      TCPU_CLK_DIV2: prescale_factor_mask = TCPU_MASK_DIV2;
      TCPU_CLK_DIV4: prescale_factor_mask = TCPU_MASK_DIV4;
      TCPU_CLK_DIV8: prescale_factor_mask = TCPU_MASK_DIV8;
      TCPU_CLK_EXT:  prescale_factor_mask = TCPU_MASK_DIV8;
    endcase
    // Edge of the external clock in the chosen direction.
    ext_edge = (ext_clock_pin != st_q.ext_prev) &&
               (ext_clock_pin == st_q.ctrl_two[TCPU_C2_EXT_EDGE]);
    // Edge of capture pin one in the chosen direction.
    cap_edge = (capture_pin_one != st_q.cap_prev) &&
               (capture_pin_one == st_q.ctrl_one[TCPU_C1_CAP_EDGE]);
    // A match is taken once, on the cycle the counter arrives at the target.
    // Slow clocks see the target one count later, matching the counter pipeline.
    cnt_moved = (counter_value != st_q.cnt_prev);
    for (int ch = 0; ch < 2; ch++) begin
      logic [15:0] target;
      target = (ch == 0) ? st_q.act_one : st_q.act_two;
      if (clk_sel != TCPU_CLK_DIV2) begin
        target = target + 16'h0001;
      end
      match[ch] = cnt_moved && (counter_value == target) && !st_q.inhibit[ch];
    end
  end

  // Next-state logic for the whole unit.
  always_comb begin
    st_d = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
    st_d.cnt_prev = counter_value;
    st_d.ext_prev = ext_clock_pin;
    st_d.cap_prev = capture_pin_one;
    st_d.load_req = 1'b0;
    st_d.cap_load = 1'b0;
    st_d.rdata    = 8'h00;

    // Tick from the prescaler or from an external edge.
    if (clk_sel == TCPU_CLK_EXT) begin
      st_d.prescale_factor = TCPU_PRESCALE_FACTOR_RESET;
      st_d.tick  = ext_edge;
    end else begin
      st_d.prescale_factor = st_q.prescale_factor + 3'h1;
      st_d.tick  = ((st_q.prescale_factor & prescale_factor_mask) == prescale_factor_mask);
    end

    // Register reads; status read arms the clear of any set flag.
    if (reg_rd) begin
      unique case (reg_addr)
        TCPU_ADDR_CTRL_ONE:  st_d.rdata = st_q.ctrl_one &
                                          ~(8'h01 << TCPU_C1_FORCE_ONE) & ~(8'h01 << TCPU_C1_FORCE_TWO);
        TCPU_ADDR_CTRL_TWO:  st_d.rdata = st_q.ctrl_two;
        TCPU_ADDR_STATUS: begin
          st_d.rdata = {6'h00, st_q.match_flag};
          st_d.clear_armed = st_q.clear_armed | st_q.match_flag;
        end
        TCPU_ADDR_CMP1_HIGH: st_d.rdata = st_q.cmp_one[15:8];
        TCPU_ADDR_CMP1_LOW:  st_d.rdata = st_q.cmp_one[7:0];
        TCPU_ADDR_CMP2_HIGH: st_d.rdata = st_q.cmp_two[15:8];
        TCPU_ADDR_CMP2_LOW:  st_d.rdata = st_q.cmp_two[7:0];
        default:             st_d.rdata = 8'h00;
      endcase
    end

    // Register writes; the compare bytes are touched only by software.
    if (reg_wr) begin
      unique case (reg_addr)
        TCPU_ADDR_CTRL_ONE:  st_d.ctrl_one = reg_wdata;
        TCPU_ADDR_CTRL_TWO:  st_d.ctrl_two = reg_wdata;
        TCPU_ADDR_CMP1_HIGH: st_d.cmp_one[15:8] = reg_wdata;
        TCPU_ADDR_CMP1_LOW:  st_d.cmp_one[7:0]  = reg_wdata;
        TCPU_ADDR_CMP2_HIGH: st_d.cmp_two[15:8] = reg_wdata;
        TCPU_ADDR_CMP2_LOW:  st_d.cmp_two[7:0]  = reg_wdata;
        default: begin
          // Status and unmapped writes are ignored.
        end
      endcase
    end

    // Per-channel interlock, flag clearing and flag setting.
    for (int ch = 0; ch < 2; ch++) begin
      logic ch_b;
      logic acc_low;
      logic set_flag;
      ch_b     = (ch == 1);
      acc_low  = (reg_wr || reg_rd) && tcpu_is_low(reg_addr, ch_b);
      // High write suspends matching; low write resumes it.
      if (reg_wr && tcpu_is_high(reg_addr, ch_b)) begin
        st_d.inhibit[ch] = 1'b1;
      end
      if (reg_wr && tcpu_is_low(reg_addr, ch_b)) begin
        st_d.inhibit[ch] = 1'b0;
      end
      // Flags never set in PWM, and flag one never set in single pulse.
      set_flag = match[ch] && !mode_pwm && !(mode_single && ch == 0);
      // Low byte access completes a clear that a status read armed.
      if (acc_low && st_q.clear_armed[ch]) begin
        st_d.match_flag[ch]  = 1'b0;
        st_d.clear_armed[ch] = 1'b0;
      end
      // A match landing in the clear cycle is kept.
      if (set_flag) begin
        st_d.match_flag[ch] = 1'b1;
      end
    end

    // Normal compare: an enabled pin takes its level on a match.
    if (!mode_pwm && !mode_single) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (match[ch] && pin_en[ch]) begin
          st_d.pin[ch] = level[ch];
        end
      end
      // Force copies the level without touching flags.
      if (reg_wr && reg_addr == TCPU_ADDR_CTRL_ONE) begin
        if (reg_wdata[TCPU_C1_FORCE_ONE] && pin_en[0]) begin
          st_d.pin[0] = reg_wdata[TCPU_C1_LEVEL_ONE];
        end
        if (reg_wdata[TCPU_C1_FORCE_TWO] && pin_en[1]) begin
          st_d.pin[1] = reg_wdata[TCPU_C1_LEVEL_TWO];
        end
      end
    end

    // Single pulse: capture edge starts the pulse, compare one ends it.
    if (mode_single) begin
      if (cap_edge) begin
        st_d.load_req = 1'b1;
        st_d.cap_load = 1'b1;
        if (pin_en[0]) begin
          st_d.pin[0] = level[1];
        end
      end else if (match[0] && pin_en[0]) begin
        st_d.pin[0] = level[0];
      end
    end

    // PWM: compare one sets level one, compare two ends the period.
    if (mode_pwm) begin
      if (match[1]) begin
        st_d.load_req = 1'b1;
        st_d.cap_load = 1'b1;
        st_d.act_one  = st_q.cmp_one;
        st_d.act_two  = st_q.cmp_two;
        if (pin_en[0]) begin
          st_d.pin[0] = level[1];
        end
      end else if (match[0] && pin_en[0]) begin
        st_d.pin[0] = level[0];
      end
    end else begin
      // Outside PWM the compared values follow software at once.
      st_d.act_one = st_q.cmp_one;
      st_d.act_two = st_q.cmp_two;
    end

    // Capture one is taken away from ordinary capture in both pulse modes.
    st_d.cap_block = mode_single || mode_pwm;

    // One request line; compare flags need enable and unmasked processor.
    st_d.irq = ~cpu_irq_mask && st_q.ctrl_one[TCPU_C1_CMP_IRQ_EN] && (|st_d.match_flag);

    // Synchronous part of the reset, after the release pipeline.
    if (!st_q.rst_sync[1]) begin
      st_d          = '0;
      st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
      st_d.cmp_one  = TCPU_CMP_RESET;
      st_d.cmp_two  = TCPU_CMP_RESET;
      st_d.act_one  = TCPU_CMP_RESET;
      st_d.act_two  = TCPU_CMP_RESET;
      st_d.pin      = 2'b00;
      st_d.cnt_prev = counter_value;
      st_d.ext_prev = ext_clock_pin;
      st_d.cap_prev = capture_pin_one;
    end
  end

  // State register; the asynchronous reset loads constants only.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q          <= '0;
      st_q.ctrl_one <= TCPU_CTRL_RESET;
      st_q.ctrl_two <= TCPU_CTRL_RESET;
      st_q.cmp_one  <= TCPU_CMP_RESET;
      st_q.cmp_two  <= TCPU_CMP_RESET;
      st_q.act_one  <= TCPU_CMP_RESET;
      st_q.act_two  <= TCPU_CMP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state record; the capture value is a constant.
  always_comb begin
    reg_rdata              = st_q.rdata;
    timer_tick             = st_q.tick;
    counter_load_req       = st_q.load_req;
    capture_one_block      = st_q.cap_block;
    capture_one_load       = st_q.cap_load;
    capture_one_value      = TCPU_CAPTURE_VALUE;
    compare_output_pin_one = st_q.pin[0];
    compare_output_pin_two = st_q.pin[1];
    compare_pin_enable_one = st_q.ctrl_two[TCPU_C2_PIN_EN_ONE];
    compare_pin_enable_two = st_q.ctrl_two[TCPU_C2_PIN_EN_TWO];
    timer_irq_req          = st_q.irq;
  end

endmodule
`default_nettype wire

// *** dv/tcpu_compare_unit_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcpu_compare_unit_asserts
  import tcpu_pkg::*;
(
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register port.
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Block outputs and mask.
  input wire logic        cpu_irq_mask,
  input wire logic        timer_tick,
  input wire logic        counter_load_req,
  input wire logic        capture_one_load,
  input wire logic [15:0] capture_one_value,
  input wire logic        compare_output_pin_one,
  input wire logic        compare_pin_enable_one,
  input wire logic        timer_irq_req
);
  logic [7:0] ctrl2_q;  // Shadow of control two, kept from the bus writes.
  logic       wr_c2;    // A write to control two is on the bus.
  assign wr_c2 = reg_wr && (reg_addr == TCPU_ADDR_CTRL_TWO);
  // The shadow lets tick spacing be judged by the divider really chosen.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl2_q <= TCPU_CTRL_RESET;
    end else if (wr_c2) begin
      ctrl2_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_rdata_idle; !reg_rd |=> (reg_rdata == 8'h00); endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_cap_value; capture_one_value == TCPU_CAPTURE_VALUE; endproperty
  a_cap_value: assert property (p_cap_value) else $error("capture value wrong");
  property p_tick_pulse; timer_tick |=> !timer_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  // Load cycles are left out as well, though a load leaves the divider running.
  property p_tick_div2;
    (timer_tick && ctrl2_q[5:4] == TCPU_CLK_DIV2 && !wr_c2 && !counter_load_req)
      ##1 (!wr_c2 && !counter_load_req) |=> timer_tick;
  endproperty
  a_tick_div2: assert property (p_tick_div2) else $error("half rate tick missing");
  property p_load_pulse; counter_load_req |=> !counter_load_req; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load request too long");
  property p_cap_load_pair; capture_one_load |-> counter_load_req; endproperty
  a_cap_load_pair: assert property (p_cap_load_pair) else $error("capture load without reload");
  property p_irq_mask; cpu_irq_mask |=> !timer_irq_req; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request while masked");
  property p_pin_en; wr_c2 |-> ##[1:2] (compare_pin_enable_one == ctrl2_q[TCPU_C2_PIN_EN_ONE]); endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin enable not applied");
  property p_pin_hold; !compare_pin_enable_one ##1 !compare_pin_enable_one |-> $stable(compare_output_pin_one); endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("disabled pin moved");
endmodule
`default_nettype wire

// *** dv/tcpu_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcpu_far_model
  import tcpu_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Requests from the block and the bench.
  input  wire logic        timer_tick,
  input  wire logic        counter_load_req,
  input  wire logic        fire,
  // Counter and pins towards the block.
  output logic      [15:0] counter_value,
  output logic             capture_pin_one,
  output logic             ext_clock_pin
);
  logic [2:0] hold_q;  // Cycles left of the capture pulse.
  logic [2:0] div_q;   // External clock divider.
  // Neighbour counter and pin drivers; a load wins over a count.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_value <= TCPU_COUNTER_LOAD;
      hold_q        <= 3'h0;
      div_q         <= 3'h0;
      ext_clock_pin <= 1'b0;
    end else begin
      if (counter_load_req) begin
        counter_value <= TCPU_COUNTER_LOAD;
      end else if (timer_tick) begin
        counter_value <= counter_value + 16'h0001;
      end
      hold_q <= fire ? 3'h4 : (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
      // Five clocks a half period keeps this well under a quarter of the rate.
      div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
      if (div_q == 3'h4) begin
        ext_clock_pin <= ~ext_clock_pin;
      end
    end
  end
  assign capture_pin_one = (hold_q != 3'h0);
endmodule
`default_nettype wire

// *** dv/tcpu_compare_unit_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcpu_compare_unit_tb
  import tcpu_pkg::*;
();
  logic        ref_clk, reset_n, reg_wr, reg_rd, cpu_irq_mask, fire;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] cnt, cap_val, t;
  logic        tick, load_req, cap_pin, ext_pin, cap_block, cap_load, pin1, pin2, en1, en2, irq;
  int          bad_count, cmp_count;
  // The clock toggles every half period.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  tcpu_compare_unit u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_value(cnt), .cpu_irq_mask(cpu_irq_mask),
    .timer_tick(tick), .counter_load_req(load_req), .capture_pin_one(cap_pin), .ext_clock_pin(ext_pin),
    .capture_one_block(cap_block), .capture_one_load(cap_load), .capture_one_value(cap_val),
    .compare_output_pin_one(pin1), .compare_output_pin_two(pin2), .compare_pin_enable_one(en1),
    .compare_pin_enable_two(en2), .timer_irq_req(irq));
  tcpu_far_model u_far (.ref_clk(ref_clk), .reset_n(reset_n), .timer_tick(tick), .counter_load_req(load_req),
    .fire(fire), .counter_value(cnt), .capture_pin_one(cap_pin), .ext_clock_pin(ext_pin));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Four-state compare, so an unknown never passes.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // High byte first, as the interlock expects.
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask
  task automatic wait_cnt(input logic [15:0] v);
    for (int n = 0; n < 3000 && cnt !== v; n++) settle(1);
    chk(cnt, v);
  endtask
  task automatic wait_load();
    for (int n = 0; n < 300 && load_req !== 1'b1; n++) settle(1);
    chk(load_req, 1'b1);
  endtask
  task automatic t_reset();
    rd(TCPU_ADDR_CMP1_HIGH, 8'h80);
    rd(TCPU_ADDR_CMP1_LOW, 8'h00);
    rd(TCPU_ADDR_CMP2_HIGH, 8'h80);
    rd(TCPU_ADDR_CMP2_LOW, 8'h00);
    rd(TCPU_ADDR_STATUS, 8'h00);
    rd(4'hf, 8'h00);
    chk({pin1, pin2}, 2'b00);
  endtask
  // Quarter rate: the pin must move only once the counter is one past the value.
  task automatic t_match();
    wr(TCPU_ADDR_CTRL_TWO, 8'h11);
    wr(TCPU_ADDR_CTRL_ONE, 8'h41);
    t = cnt + 16'h0008;
    wr(TCPU_ADDR_CMP1_HIGH, t[15:8]);
    rd(TCPU_ADDR_STATUS, 8'h00);
    wr(TCPU_ADDR_CMP1_LOW, t[7:0]);
    wait_cnt(t);
    for (int i = 0; i < 8 && cnt === t; i++) begin
      chk(pin1, 1'b0);
      settle(1);
    end
    for (int i = 0; i < 4 && pin1 !== 1'b1; i++) settle(1);
    chk(pin1, 1'b1);
    chk(cnt, t + 16'h0001);
    chk(irq, 1'b1);
    @(posedge ref_clk) cpu_irq_mask <= 1'b1;
    settle(2);
    chk(irq, 1'b0);
    @(posedge ref_clk) cpu_irq_mask <= 1'b0;
    settle(2);
    chk(irq, 1'b1);
    rd(TCPU_ADDR_CMP1_LOW, t[7:0]);
    rd(TCPU_ADDR_STATUS, 8'h01);
    rd(TCPU_ADDR_CMP1_LOW, t[7:0]);
    rd(TCPU_ADDR_STATUS, 8'h00);
    chk(irq, 1'b0);
  endtask
  // A lone high byte write must silence the channel until the low byte follows.
  task automatic t_inhibit();
    wr(TCPU_ADDR_CTRL_ONE, 8'h40);
    t = cnt + 16'h0006;
    wr16(TCPU_ADDR_CMP1_HIGH, t);
    wr(TCPU_ADDR_CMP1_HIGH, t[15:8]);
    wait_cnt(t + 16'h0002);
    settle(4);
    rd(TCPU_ADDR_STATUS, 8'h00);
    chk(pin1, 1'b1);
    t = cnt + 16'h0006;
    wr16(TCPU_ADDR_CMP1_HIGH, t);
    wait_cnt(t + 16'h0002);
    settle(3);
    chk(pin1, 1'b0);
    rd(TCPU_ADDR_STATUS, 8'h01);
    wr(TCPU_ADDR_CMP1_LOW, t[7:0]);
    rd(TCPU_ADDR_STATUS, 8'h00);
  endtask
  // Interrupt enable is on for the first force so a forced level that raised a flag would show.
  task automatic t_force();
    wr(TCPU_ADDR_CTRL_ONE, 8'h45);
    settle(2);
    chk(pin1, 1'b1);
    rd(TCPU_ADDR_STATUS, 8'h00);
    chk(irq, 1'b0);
    wr(TCPU_ADDR_CTRL_ONE, 8'h04);
    settle(2);
    chk(pin1, 1'b0);
    wr(TCPU_ADDR_CTRL_TWO, 8'h05);
    wr(TCPU_ADDR_CTRL_ONE, 8'h05);
    settle(2);
    chk(pin1, 1'b0);
    chk(cap_block, 1'b1);
  endtask
  // Each trigger starts a pulse; equal levels must give a flat pin.
  task automatic t_single(input logic [7:0] c1, input logic lvl);
    wr(TCPU_ADDR_CTRL_ONE, c1);
    wr16(TCPU_ADDR_CMP1_HIGH, 16'h0010);
    @(posedge ref_clk) fire <= 1'b1;
    @(posedge ref_clk) fire <= 1'b0;
    for (int i = 0; i < 4 && load_req !== 1'b1; i++) settle(1);
    chk({load_req, cap_load, pin1}, 3'b111);
    chk(cap_val, TCPU_CAPTURE_VALUE);
    wait_cnt(16'h0010);
    settle(4);
    chk(pin1, lvl);
    rd(TCPU_ADDR_STATUS, 8'h00);
  endtask
  // Both mode bits: the period is set by value two and new values wait for it.
  task automatic t_pwm();
    wr(TCPU_ADDR_CTRL_ONE, 8'h01);
    wr16(TCPU_ADDR_CMP2_HIGH, 16'h0040);
    wr16(TCPU_ADDR_CMP1_HIGH, 16'h0020);
    wr(TCPU_ADDR_CTRL_TWO, 8'h0d);
    wait_load();
    chk(cap_load, 1'b1);
    settle(1);
    chk(cnt, TCPU_COUNTER_LOAD);
    wait_cnt(16'h0008);
    wr16(TCPU_ADDR_CMP1_HIGH, 16'h0030);
    @(posedge ref_clk) fire <= 1'b1;
    @(posedge ref_clk) fire <= 1'b0;
    wait_cnt(16'h0012);
    chk(pin1, 1'b0);
    wait_cnt(16'h002a);
    chk(pin1, 1'b1);
    wait_load();
    settle(1);
    wait_cnt(16'h002a);
    chk(pin1, 1'b0);
    rd(TCPU_ADDR_STATUS, 8'h00);
  endtask
  // Channel two on a slow divider; a lone high write keeps channel one quiet.
  task automatic t_two(input logic [7:0] c2, input logic lvl);
    wr(TCPU_ADDR_CMP1_HIGH, 8'h80);
    wr(TCPU_ADDR_CTRL_TWO, c2);
    wr(TCPU_ADDR_CTRL_ONE, {6'h00, lvl, 1'b0});
    t = cnt + 16'h0003;
    wr16(TCPU_ADDR_CMP2_HIGH, t);
    wait_cnt(t + 16'h0001);
    settle(2);
    chk({en2, pin2}, {1'b1, lvl});
    rd(TCPU_ADDR_STATUS, 8'h02);
    rd(TCPU_ADDR_CMP2_LOW, t[7:0]);
    rd(TCPU_ADDR_STATUS, 8'h00);
  endtask
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    cpu_irq_mask = 1'b0;
    fire = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_match();
    t_inhibit();
    t_force();
    t_single(8'h12, 1'b0);
    t_single(8'h13, 1'b1);
    t_pwm();
    t_two(8'h22, 1'b1);
    t_two(8'h12, 1'b0);
    give_verdict();
  end
  // The whole sequence needs a few thousand cycles at most.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
bind tcpu_compare_unit tcpu_compare_unit_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_irq_mask(cpu_irq_mask), .timer_tick(timer_tick), .counter_load_req(counter_load_req),
  .capture_one_load(capture_one_load), .capture_one_value(capture_one_value),
  .compare_output_pin_one(compare_output_pin_one), .compare_pin_enable_one(compare_pin_enable_one),
  .timer_irq_req(timer_irq_req));
`default_nettype wire
